//--- src/hpcr_pkg.sv
// Constants for the hub port configuration register bank.
package hpcr_pkg;
   localparam int unsigned NUM_PORTS       = 3;
   localparam int unsigned ADDR_W          = 10;
   // Register indices; the byte address is four times the index.
   localparam logic [7:0]  IDX_CFG_ONE     = 8'h06;
   localparam logic [7:0]  IDX_CFG_TWO     = 8'h07;
   localparam logic [7:0]  IDX_CFG_THREE   = 8'h08;
   localparam logic [7:0]  IDX_FIXED       = 8'h09;
   localparam logic [7:0]  IDX_SP_OFF      = 8'h0a;
   localparam logic [7:0]  IDX_BP_OFF      = 8'h0b;
   localparam logic [7:0]  IDX_REMAP       = 8'hfb;
   localparam logic [7:0]  IDX_STATUS      = 8'h10;
   // Writable bit masks; all other bits are reserved.
   localparam logic [7:0]  MASK_CFG_ONE    = 8'h01;
   localparam logic [7:0]  MASK_CFG_TWO    = 8'h08;
   localparam logic [7:0]  MASK_CFG_THREE  = 8'h09;
   localparam logic [7:0]  MASK_PORTS      = 8'h0e;
   localparam logic [7:0]  MASK_REMAP      = 8'hfc;
   // Field positions.
   localparam int unsigned BIT_PWR_MODE    = 0;
   localparam int unsigned BIT_COMPOUND    = 3;
   localparam int unsigned BIT_REMAP_SEL   = 3;
   localparam int unsigned BIT_STRING_EN   = 0;
   // Reset values.
   localparam logic [7:0]  RST_CFG         = 8'h00;
   localparam logic [7:0]  RST_PORTS       = 8'h00;
   localparam logic [7:0]  RST_REMAP       = 8'he4;
endpackage : hpcr_pkg

//--- src/hpcr_regs.sv
// Hub port configuration register bank with port numbering and power switching.
module hpcr_regs
   import hpcr_pkg::*;
(
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic              self_powered_pin,
   input  wire logic [3:1]        port_power_req,
   output logic      [3:1]        port_power_on,
   output logic      [3:1]        port_enable,
   output logic      [5:0]        port_number,
   output logic      [1:0]        ports_reported,
   output logic                   power_switch_mode_o,
   output logic                   compound_flag,
   output logic                   string_desc_en,
   output logic      [3:1]        fixed_attach_report
);

   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
      return a == {idx, 2'b00};
   endfunction

   // Standard numbering: count of enabled ports at or below the given one, zero for a disabled port.
   function automatic logic [1:0] std_num(input logic [3:1] en, input int unsigned p);
      logic [1:0] n;
      n = 2'd0;
      for (int unsigned i = 1; i <= NUM_PORTS; i++) begin
         if (i <= p && en[i]) begin
            n = n + 2'd1;
         end
      end
      return en[p] ? n : 2'd0;
   endfunction

   logic [7:0] cfg_one_r;
   logic [7:0] cfg_two_r;
   logic [7:0] cfg_three_r;
   logic [7:0] fixed_attach_ports_r;
   logic [7:0] sp_off_r;
   logic [7:0] bp_off_r;
   logic [7:0] remap_r;
   logic       sp_meta_r;
   logic       sp_sync_r;

   wire        setup_ph   = psel && !penable;
   wire        wr_take    = psel && penable && pready && pwrite;
   wire        hit_one    = hit(paddr, IDX_CFG_ONE);
   wire        hit_two    = hit(paddr, IDX_CFG_TWO);
   wire        hit_three  = hit(paddr, IDX_CFG_THREE);
   wire        hit_fixed  = hit(paddr, IDX_FIXED);
   wire        hit_sp     = hit(paddr, IDX_SP_OFF);
   wire        hit_bp     = hit(paddr, IDX_BP_OFF);
   wire        hit_remap  = hit(paddr, IDX_REMAP);
   wire        hit_stat   = hit(paddr, IDX_STATUS);
   wire        mapped     = hit_one | hit_two | hit_three | hit_fixed | hit_sp | hit_bp | hit_remap | hit_stat;
   wire [7:0]  wbyte      = pwdata[7:0];

   wire        remap_sel  = cfg_three_r[BIT_REMAP_SEL];
   wire [7:0]  off_mask   = sp_sync_r ? sp_off_r : bp_off_r;
   wire [3:1]  std_en     = ~off_mask[3:1];
   // A zero table entry leaves that physical port disabled in remap mode.
   wire [3:1]  rmp_en     = {remap_r[7:6] != 2'd0, remap_r[5:4] != 2'd0, remap_r[3:2] != 2'd0};
   wire [3:1]  en_nxt     = remap_sel ? rmp_en : std_en;
   wire [5:0]  std_nums   = {std_num(std_en, 3), std_num(std_en, 2), std_num(std_en, 1)};
   wire [5:0]  num_nxt    = remap_sel ? remap_r[7:2] : std_nums;
   wire [1:0]  count_nxt  = std_num(en_nxt, 3);
   wire        any_req    = |port_power_req;

   // Requests arrive indexed by reported number; fold them back to physical ports.
   logic [3:1] indiv_pwr;
   logic [3:1] fixed_nxt;
   always_comb begin
      indiv_pwr = 3'b000;
      fixed_nxt = 3'b000;
      for (int unsigned p = 1; p <= NUM_PORTS; p++) begin
         if (en_nxt[p] && num_nxt[2*p-2 +: 2] != 2'd0) begin
            indiv_pwr[p] = port_power_req[num_nxt[2*p-2 +: 2]];
            fixed_nxt[num_nxt[2*p-2 +: 2]] = fixed_attach_ports_r[p];
         end
      end
   end

   wire [3:1]  pwr_nxt    = cfg_one_r[BIT_PWR_MODE] ? indiv_pwr : (en_nxt & {3{any_req}});

   // Read decode; unmapped addresses and reserved bits read as zero.
   logic [7:0] rd_byte;
   always_comb begin
      case (1'b1)
         hit_one:   rd_byte = cfg_one_r;
         hit_two:   rd_byte = cfg_two_r;
         hit_three: rd_byte = cfg_three_r;
         hit_fixed: rd_byte = fixed_attach_ports_r;
         hit_sp:    rd_byte = sp_off_r;
         hit_bp:    rd_byte = bp_off_r;
         hit_remap: rd_byte = remap_r;
         hit_stat:  rd_byte = {sp_sync_r, 2'b00, count_nxt, en_nxt};
         default:   rd_byte = 8'h00;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sp_meta_r <= 1'b0;
         sp_sync_r <= 1'b0;
      end else begin
         sp_meta_r <= self_powered_pin;
         sp_sync_r <= sp_meta_r;
      end
   end

   // Answer in the first access cycle; read data is latched in the setup cycle.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= setup_ph;
         pslverr <= setup_ph && !mapped;
         if (setup_ph && !pwrite) begin
            prdata <= {24'h00_0000, rd_byte};
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_one_r            <= RST_CFG;
         cfg_two_r            <= RST_CFG;
         cfg_three_r          <= RST_CFG;
         fixed_attach_ports_r <= RST_PORTS;
         sp_off_r             <= RST_PORTS;
         bp_off_r             <= RST_PORTS;
         remap_r              <= RST_REMAP;
      end else if (wr_take) begin
         if (hit_one)   cfg_one_r            <= wbyte & MASK_CFG_ONE;
         if (hit_two)   cfg_two_r            <= wbyte & MASK_CFG_TWO;
         if (hit_three) cfg_three_r          <= wbyte & MASK_CFG_THREE;
         if (hit_fixed) fixed_attach_ports_r <= wbyte & MASK_PORTS;
         if (hit_sp)    sp_off_r             <= wbyte & MASK_PORTS;
         if (hit_bp)    bp_off_r             <= wbyte & MASK_PORTS;
         if (hit_remap) remap_r              <= wbyte & MASK_REMAP;
      end
   end

   // Every port output is registered so the host side never sees decode glitches.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         port_power_on       <= 3'b000;
         port_enable         <= 3'b000;
         port_number         <= 6'h00;
         ports_reported      <= 2'd0;
         power_switch_mode_o <= 1'b0;
         compound_flag       <= 1'b0;
         string_desc_en      <= 1'b0;
         fixed_attach_report <= 3'b000;
      end else begin
         port_power_on       <= pwr_nxt;
         port_enable         <= en_nxt;
         port_number         <= num_nxt;
         ports_reported      <= count_nxt;
         power_switch_mode_o <= cfg_one_r[BIT_PWR_MODE];
         compound_flag       <= cfg_two_r[BIT_COMPOUND];
         string_desc_en      <= cfg_three_r[BIT_STRING_EN];
         fixed_attach_report <= fixed_nxt;
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // Bus answer and register field checks.
   apb_ready_a: assert property (setup_ph |=> pready && !$past(mapped) == pslverr)
      else $error("apb answer not in first access cycle");
   compound_write_a: assert property (wr_take && hit_two |->
         ##2 compound_flag == $past(pwdata[BIT_COMPOUND], 2))
      else $error("compound flag does not follow write");
   string_write_a: assert property (wr_take && hit_three |->
         ##2 string_desc_en == $past(pwdata[BIT_STRING_EN], 2))
      else $error("string enable does not follow write");
   reserved_read_a: assert property (setup_ph && !pwrite && (hit_two || hit_three) |=>
         (prdata & 32'hffff_fff6) == 32'h0)
      else $error("reserved bits read nonzero");
   ganged_power_a: assert property (!cfg_one_r[BIT_PWR_MODE] |=>
         port_power_on == 3'b000 || port_power_on == port_enable)
      else $error("ganged ports switched apart");
   std_disable_a: assert property (!remap_sel |=> port_enable == ~$past(off_mask[3:1]))
      else $error("standard enable does not follow disable mask");
   std_select_a: assert property (!remap_sel && sp_sync_r |=> port_enable == ~$past(sp_off_r[3:1]))
      else $error("self powered mask not selected");
   std_contig_a: assert property (!remap_sel && std_en == 3'b101 |=> port_number == 6'b10_00_01)
      else $error("standard numbers not contiguous");
   remap_table_a: assert property (remap_sel |=> port_number == $past(remap_r[7:2]))
      else $error("remap numbering not taken from table");
   fixed_report_a: assert property (!remap_sel && std_en == 3'b111 |=>
         fixed_attach_report == $past(fixed_attach_ports_r[3:1]))
      else $error("fixed attach flags not reported");

   // The supply pin passes two flops; only the second one feeds the mask select.
   sync_path_a: assert property ($past(presetn) && $past(presetn, 2) |->
         sp_sync_r == $past(self_powered_pin, 2))
      else $error("supply pin not seen through two flops");
   count_match_a: assert property (ports_reported == 2'($countones(port_enable)))
      else $error("reported count differs from enabled ports");
   off_unpowered_a: assert property ((port_power_on & ~port_enable) == 3'b000)
      else $error("disabled port is powered");
   unmapped_write_a: assert property (wr_take && !mapped |=>
         $stable(cfg_one_r) && $stable(cfg_two_r) && $stable(cfg_three_r) && $stable(fixed_attach_ports_r))
      else $error("write to unmapped address changed a register");
   fixed_reserved_a: assert property (setup_ph && !pwrite && hit_fixed |=>
         prdata[0] == 1'b0 && prdata[7:4] == 4'h0)
      else $error("reserved fixed attach bits read nonzero");
   std_number_a: assert property (!remap_sel && std_en == 3'b111 |=> port_number == 6'b11_10_01)
      else $error("standard numbers differ from physical numbers");

endmodule // hpcr_regs

//--- verif/hpcr_host_model.sv
// Upstream-side model that drives the supply pin and the power requests.
module hpcr_host_model (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       self_cmd,
   input  wire logic [3:1] req_cmd,
   output logic            self_powered_pin,
   output logic      [3:1] port_power_req
);
   timeunit 1ns;
   timeprecision 1ps;
   // Levels change just after a rising edge, never mid-cycle.
   // Fixed devices answer for their own descriptors; nothing here expects them from the hub.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         self_powered_pin <= 1'b0;
         port_power_req   <= '0;
      end else begin
         self_powered_pin <= self_cmd;
         port_power_req   <= req_cmd;
      end
   end
endmodule // hpcr_host_model

//--- verif/tb_top.sv
// Self-checking bench for the hub port configuration register bank.
module tb_top
   import hpcr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic              pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic              self_cmd, self_powered_pin, power_switch_mode_o, compound_flag, string_desc_en;
   logic [ADDR_W-1:0] paddr;
   logic [31:0]       pwdata, prdata;
   logic [3:1]        req_cmd, port_power_req, port_power_on, port_enable, fixed_attach_report;
   logic [5:0]        port_number;
   logic [1:0]        ports_reported;
   logic [7:0]        rd;
   int                num_errors = 0;
   int                total_checks = 0;
   hpcr_regs uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .self_powered_pin, .port_power_req, .port_power_on, .port_enable, .port_number, .ports_reported,
      .power_switch_mode_o, .compound_flag, .string_desc_en, .fixed_attach_report);
   hpcr_host_model host (.pclk, .presetn, .self_cmd, .req_cmd, .self_powered_pin, .port_power_req);
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= {idx, 2'b00};
      pwdata  <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd      = prdata[7:0];
      err     = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic tk(input int n);
      repeat (n) @(posedge pclk);
   endtask
   task automatic t_reset;
      chk(8'(port_enable), 8'h07);
      chk(8'(port_number), 8'h39);
      apb(1'b0, IDX_CFG_TWO, 8'h00);
      chk(rd, 8'h00);
      apb(1'b0, 8'h3f, 8'h00);
      chk(8'(err), 8'h01);
      apb(1'b1, 8'h3f, 8'hff);
      chk(8'(err), 8'h01);
   endtask
   task automatic t_fields;
      apb(1'b1, IDX_CFG_TWO, 8'hff);
      apb(1'b1, IDX_FIXED, 8'hff);
      apb(1'b0, IDX_CFG_TWO, 8'h00);
      chk(rd, 8'h08);
      apb(1'b0, IDX_FIXED, 8'h00);
      chk(rd, 8'h0e);
      apb(1'b1, IDX_CFG_THREE, 8'hf7);
      apb(1'b0, IDX_CFG_THREE, 8'h00);
      chk(rd, 8'h01);
      tk(3);
      chk(8'(compound_flag), 8'h01);
      chk(8'(string_desc_en), 8'h01);
      chk(8'(fixed_attach_report), 8'h07);
      apb(1'b1, IDX_CFG_TWO, 8'h00);
      apb(1'b1, IDX_CFG_THREE, 8'h00);
      tk(3);
      chk(8'(compound_flag), 8'h00);
      chk(8'(string_desc_en), 8'h00);
   endtask
   task automatic t_std;
      self_cmd <= 1'b1;
      apb(1'b1, IDX_SP_OFF, 8'h04);
      apb(1'b1, IDX_BP_OFF, 8'h02);
      apb(1'b1, IDX_FIXED, 8'h08);
      req_cmd <= 3'b100;
      tk(8);
      chk(8'(port_enable), 8'h05);
      chk(8'(port_number), 8'h21);
      chk(8'(ports_reported), 8'h02);
      chk(8'(fixed_attach_report), 8'h02);
      chk(8'(port_power_on), 8'h05);
      apb(1'b0, IDX_STATUS, 8'h00);
      chk(rd, 8'h95);
      self_cmd <= 1'b0;
      apb(1'b1, IDX_CFG_ONE, 8'h01);
      req_cmd <= 3'b001;
      tk(8);
      chk(8'(port_number), 8'h24);
      chk(8'(power_switch_mode_o), 8'h01);
      chk(8'(port_power_on), 8'h02);
   endtask
   task automatic t_remap;
      apb(1'b1, IDX_CFG_THREE, 8'h08);
      apb(1'b1, IDX_REMAP, 8'h6c);
      tk(4);
      chk(8'(port_enable), 8'h07);
      chk(8'(port_number), 8'h1b);
      chk(8'(ports_reported), 8'h03);
      chk(8'(port_power_on), 8'h04);
      chk(8'(fixed_attach_report), 8'h01);
   endtask
   task automatic close_out;
      if (num_errors == 0 && total_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   initial begin
      repeat (3000) @(posedge pclk);
      num_errors++;
      close_out;
   end
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      self_cmd = 1'b0;
      req_cmd = '0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      tk(3);
      t_reset;
      t_fields;
      t_std;
      t_remap;
      close_out;
   end
endmodule // tb_top
